/* core/drive_supervision.sv */
// drive supervision: item store, stall watch, frequency output, user output, monitors
// assumes a host writes items through the item port; pins are asynchronous
// How it works
// - initial stall suppressed for 2.0-25.0 s
// - main stall after running timeout; 0 disables
// - main ppr 1-2500, rate up to 1.2M ppm
// - frequency output at set ppm; 0 disables
// - leader stall after timeout; no initial check
// - leader ppr 1-2500, same rate limit
// - drive polarity 0 normal, 1 inverted
// - speed display refresh 0.2-8.0 s
// - program bounded by min/max, min<=max
// - access levels locked, free, code required
// - pushbutton target: speed, program, frequency
// - code zero bypasses, 1-9999 is code
// - lockout weights sum, 31 enables all
// - address zero ignores all messages
// - baud code 1-5 selects 300..9600
// - reply delay in 10 ms units, 1-50
// - analog routing code 0-6
// - user output open at 0, closed at 1
// - assignment mask selects status flags
// - inversion mask inverts selected flags
// - status word sums flag weights
// - pickup rpm reported unaveraged
module drive_supervision
  import drive_supervision_pkg::*;
#(
  parameter logic [15:0] DEVICE_TYPE = 16'h00aa, // arbitrary value
  parameter logic [15:0] SW_REV = 16'h0001, // arbitrary value
  parameter logic [15:0] COMMS_REV = 16'h0001 // arbitrary value
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PICKUP_PIN,
  input wire logic LEADER_PIN,
  input wire logic RUN,
  input wire logic RAMP_ACTIVE,
  input wire logic INHIBIT,
  input wire logic BELOW_LIMIT,
  input wire logic ABOVE_LIMIT,
  input wire logic COND_MAX,
  input wire logic DRIVE_RAW,
  input wire logic WR_EN,
  input wire drive_supervision_pkg::item_write_t WR,
  output drive_supervision_pkg::item_answer_t WR_ANS,
  input wire logic RD_EN,
  input wire logic [7:0] RD_PAGE,
  input wire logic [7:0] RD_ITEM,
  output drive_supervision_pkg::item_answer_t RD_ANS,
  input wire logic MSG_VALID,
  input wire logic [15:0] MSG_ADDR,
  output logic MSG_ACCEPT,
  output logic REPLY_GO,
  output logic [15:0] BAUD_RATE,
  output logic BTN_UP,
  output logic BTN_DOWN,
  input wire logic KEY_UP,
  input wire logic KEY_DOWN,
  input wire logic CODE_OK,
  output logic [2:0] PROGRAM,
  output logic [15:0] TARGET,
  output logic [4:0] MENU_ENABLE,
  output logic [2:0] ANALOG_ROUTE,
  output logic DISPLAY_STROBE,
  output logic [15:0] DISPLAY_RPM,
  output logic FREQ_OUT,
  output logic DRIVE_OUT,
  output logic MAIN_SHUTDOWN,
  output logic LEADER_STOPPED,
  output logic USER_OUT
);
  import drive_supervision_pkg::*;
`include "drive_supervision_cfg.svh"

  logic [1:0] pick_sync, lead_sync;
  logic pick_last, lead_last, pick_pulse, lead_pulse;
  logic [15:0] init_stall, run_stall, pick_ppr, freq_rate, lead_stall, lead_ppr;
  logic drive_inv;
  logic [15:0] update_rate, prog_min, prog_max, address, baud, turn, route;
  logic [15:0] code, lockout, umask, uinv, dest;
  logic [1:0] acc_prog, acc_target, acc_freq;
  logic user_nc;
  logic ok_value;
  logic [23:0] init_tick;
  logic [15:0] init_tenths;
  logic init_done;
  logic main_stall, lead_stall_flag;
  logic [15:0] pick_rpm, lead_rpm;
  logic [7:0] status;
  logic [6:0] selected;
  logic [23:0] upd_tick;
  logic [15:0] upd_tenths;
  logic [39:0] freq_acc;
  logic [23:0] turn_tick;
  logic [15:0] turn_units;
  logic turn_busy;
  logic [15:0] next_value;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pick_sync <= 2'b00;
      lead_sync <= 2'b00;
      pick_last <= 1'b0;
      lead_last <= 1'b0;
    end else begin
      pick_sync <= {pick_sync[0], PICKUP_PIN};
      lead_sync <= {lead_sync[0], LEADER_PIN};
      pick_last <= pick_sync[1];
      lead_last <= lead_sync[1];
    end
  end
  // one pulse per cycle is ample: 1.2M ppm is 20 kHz against 125 MHz
  assign pick_pulse = pick_sync[1] & ~pick_last;
  assign lead_pulse = lead_sync[1] & ~lead_last;

  // write validation: out-of-range values are refused
  always_comb begin
    ok_value = 1'b0;
    case (WR.page)
      `PAGE_CONTROL: begin
        case (WR.item)
          8'h05: ok_value = WR.value >= `INIT_STALL_MIN && WR.value <= `INIT_STALL_MAX;
          8'h06: ok_value = WR.value <= `RUN_STALL_MAX;
          8'h07: ok_value = WR.value >= 16'd1 && WR.value <= `PPR_MAX;
          8'h08: ok_value = WR.value <= `FREQ_MAX;
          8'h09: ok_value = WR.value <= `RUN_STALL_MAX;
          8'h0a: ok_value = WR.value >= 16'd1 && WR.value <= `PPR_MAX;
          8'h0b: ok_value = WR.value <= 16'd1;
          8'h0c: ok_value = WR.value >= `UPDATE_MIN && WR.value <= `UPDATE_MAX;
          default: ok_value = 1'b0;
        endcase
      end
      `PAGE_PROGRAM: begin
        case (WR.item)
          8'h01: ok_value = WR.value >= prog_min && WR.value <= prog_max;
          8'h02: ok_value = WR.value >= `PROG_MIN && WR.value <= prog_max;
          8'h03: ok_value = WR.value >= prog_min && WR.value <= `PROG_MAX;
          default: ok_value = 1'b0;
        endcase
      end
      `PAGE_ACCESS: begin
        case (WR.item)
          8'h01, 8'h02, 8'h03: ok_value = WR.value <= `ACCESS_MAX;
          8'h04: ok_value = WR.value >= `DEST_MIN && WR.value <= `DEST_MAX;
          8'h05: ok_value = WR.value <= `CODE_MAX;
          8'h06: ok_value = WR.value <= `LOCKOUT_ALL;
          default: ok_value = 1'b0;
        endcase
      end
      `PAGE_NETWORK: begin
        case (WR.item)
          8'h01: ok_value = 1'b1;
          8'h02: ok_value = WR.value >= `BAUD_MIN && WR.value <= `BAUD_MAX;
          8'h03: ok_value = WR.value >= `TURN_MIN && WR.value <= `TURN_MAX;
          default: ok_value = 1'b0;
        endcase
      end
      `PAGE_ANALOG: ok_value = WR.item == 8'h01 && WR.value <= `ROUTE_MAX;
      `PAGE_USER_OUT: begin
        case (WR.item)
          8'h02: ok_value = WR.value <= 16'd1;
          8'h03, 8'h04: ok_value = WR.value <= 16'd127;
          default: ok_value = 1'b0;
        endcase
      end
      default: ok_value = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      init_stall <= `INIT_STALL_RST;
      run_stall <= 16'h0000;
      pick_ppr <= 16'h0001;
      freq_rate <= 16'h0000;
      lead_stall <= `LEADER_STALL_RST;
      lead_ppr <= 16'h0001;
      drive_inv <= 1'b0;
      update_rate <= `UPDATE_RST;
      prog_min <= `PROG_MIN;
      prog_max <= `PROG_MAX;
      address <= 16'h0000;
      baud <= `BAUD_MAX;
      turn <= `TURN_MIN;
      route <= 16'h0000;
      code <= 16'h0000;
      lockout <= `LOCKOUT_ALL;
      umask <= 16'h0000;
      uinv <= 16'h0000;
      dest <= `DEST_MIN;
      acc_prog <= 2'd1;
      acc_target <= 2'd1;
      acc_freq <= 2'd1;
      user_nc <= 1'b0;
      WR_ANS <= '0;
    end else begin
      WR_ANS.ok <= WR_EN & ok_value;
      WR_ANS.value <= WR.value;
      if (WR_EN && ok_value) begin
        case ({WR.page, WR.item})
          {`PAGE_CONTROL, 8'h05}: init_stall <= WR.value;
          {`PAGE_CONTROL, 8'h06}: run_stall <= WR.value;
          {`PAGE_CONTROL, 8'h07}: pick_ppr <= WR.value;
          {`PAGE_CONTROL, 8'h08}: freq_rate <= WR.value;
          {`PAGE_CONTROL, 8'h09}: lead_stall <= WR.value;
          {`PAGE_CONTROL, 8'h0a}: lead_ppr <= WR.value;
          {`PAGE_CONTROL, 8'h0b}: drive_inv <= WR.value[0];
          {`PAGE_CONTROL, 8'h0c}: update_rate <= WR.value;
          {`PAGE_PROGRAM, 8'h02}: prog_min <= WR.value;
          {`PAGE_PROGRAM, 8'h03}: prog_max <= WR.value;
          {`PAGE_ACCESS, 8'h01}: acc_prog <= WR.value[1:0];
          {`PAGE_ACCESS, 8'h02}: acc_target <= WR.value[1:0];
          {`PAGE_ACCESS, 8'h03}: acc_freq <= WR.value[1:0];
          {`PAGE_ACCESS, 8'h04}: dest <= WR.value;
          {`PAGE_ACCESS, 8'h05}: code <= WR.value;
          {`PAGE_ACCESS, 8'h06}: lockout <= WR.value;
          {`PAGE_NETWORK, 8'h01}: address <= WR.value;
          {`PAGE_NETWORK, 8'h02}: baud <= WR.value;
          {`PAGE_NETWORK, 8'h03}: turn <= WR.value;
          {`PAGE_ANALOG, 8'h01}: route <= WR.value;
          {`PAGE_USER_OUT, 8'h02}: user_nc <= WR.value[0];
          {`PAGE_USER_OUT, 8'h03}: umask <= WR.value;
          {`PAGE_USER_OUT, 8'h04}: uinv <= WR.value;
          default: ;
        endcase
      end
    end
  end

  // start timer: counts tenths from RUN rising; main stall flag held off until done
  always_ff @(posedge CLOCK) begin
    if (RST || !RUN) begin
      init_tick <= 24'h000000;
      init_tenths <= 16'h0000;
      init_done <= 1'b0;
    end else if (!init_done) begin
      if (init_tenths >= init_stall)
        init_done <= 1'b1;
      else if (init_tick == 24'(`TENTH_SEC_CYCLES - 1)) begin
        init_tick <= 24'h000000;
        init_tenths <= init_tenths + 16'h0001;
      end else
        init_tick <= init_tick + 24'h000001;
    end
  end

  stall_timer main_watch (
    .clk(CLOCK),
    .rst(RST),
    .arm(RUN & init_done),
    .pulse(pick_pulse),
    .timeout(run_stall),
    .stalled(main_stall)
  );

  // leader is armed at once: no initial hold-off on this input
  stall_timer leader_watch (
    .clk(CLOCK),
    .rst(RST),
    .arm(RUN),
    .pulse(lead_pulse),
    .timeout(lead_stall),
    .stalled(lead_stall_flag)
  );

  pulse_rate main_rate (
    .clk(CLOCK),
    .rst(RST),
    .pulse(pick_pulse),
    .ppr(pick_ppr),
    .rpm(pick_rpm)
  );

  pulse_rate leader_rate (
    .clk(CLOCK),
    .rst(RST),
    .pulse(lead_pulse),
    .ppr(lead_ppr),
    .rpm(lead_rpm)
  );

  assign status = {1'b0, COND_MAX, ABOVE_LIMIT, BELOW_LIMIT, INHIBIT, RAMP_ACTIVE,
                   lead_stall_flag, main_stall};
  assign selected = (status[6:0] ^ uinv[6:0]) & umask[6:0];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      MAIN_SHUTDOWN <= 1'b0;
      LEADER_STOPPED <= 1'b0;
      USER_OUT <= 1'b0;
      DRIVE_OUT <= 1'b0;
    end else begin
      MAIN_SHUTDOWN <= main_stall;
      LEADER_STOPPED <= lead_stall_flag;
      USER_OUT <= (|selected) ^ user_nc;
      DRIVE_OUT <= DRIVE_RAW ^ drive_inv;
    end
  end

  // display refresh timer
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      upd_tick <= 24'h000000;
      upd_tenths <= 16'h0000;
      DISPLAY_STROBE <= 1'b0;
      DISPLAY_RPM <= 16'h0000;
    end else begin
      DISPLAY_STROBE <= 1'b0;
      if (upd_tick == 24'(`TENTH_SEC_CYCLES - 1)) begin
        upd_tick <= 24'h000000;
        if (upd_tenths + 16'h0001 >= update_rate) begin
          upd_tenths <= 16'h0000;
          DISPLAY_STROBE <= 1'b1;
          DISPLAY_RPM <= pick_rpm;
        end else
          upd_tenths <= upd_tenths + 16'h0001;
      end else
        upd_tick <= upd_tick + 24'h000001;
    end
  end

  // phase accumulator: wraps once per output edge, twice per output pulse, rate in pulses per minute
  always_ff @(posedge CLOCK) begin
    if (RST || freq_rate == 16'h0000) begin
      freq_acc <= 40'h0;
      FREQ_OUT <= 1'b0;
    end else if (freq_acc + 40'(freq_rate) * 40'd2 >= 40'(`MINUTE_CYCLES)) begin
      freq_acc <= freq_acc + 40'(freq_rate) * 40'd2 - 40'(`MINUTE_CYCLES);
      FREQ_OUT <= ~FREQ_OUT;
    end else
      freq_acc <= freq_acc + 40'(freq_rate) * 40'd2;
  end

  // message filter and turnaround delay
  assign MSG_ACCEPT = MSG_VALID && address != 16'h0000 && MSG_ADDR == address;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      turn_busy <= 1'b0;
      turn_tick <= 24'h000000;
      turn_units <= 16'h0000;
      REPLY_GO <= 1'b0;
    end else begin
      REPLY_GO <= 1'b0;
      if (MSG_ACCEPT) begin
        turn_busy <= 1'b1;
        turn_tick <= 24'h000000;
        turn_units <= 16'h0000;
      end else if (turn_busy) begin
        if (turn_tick == 24'(`MS10_CYCLES - 1)) begin
          turn_tick <= 24'h000000;
          if (turn_units + 16'h0001 >= turn) begin
            turn_busy <= 1'b0;
            REPLY_GO <= 1'b1;
          end else
            turn_units <= turn_units + 16'h0001;
        end else
          turn_tick <= turn_tick + 24'h000001;
      end
    end
  end

  always_comb begin
    case (baud)
      16'd1: BAUD_RATE = 16'd300;
      16'd2: BAUD_RATE = 16'd1200;
      16'd3: BAUD_RATE = 16'd2400;
      16'd4: BAUD_RATE = 16'd4800;
      default: BAUD_RATE = 16'd9600;
    endcase
  end

  // front panel: keys act on the chosen destination when access permits
  function automatic logic allowed(input logic [1:0] lvl, input logic ok);
    allowed = lvl == ACCESS_FREE || (lvl == ACCESS_CODE && (ok || code == 16'h0000));
  endfunction

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PROGRAM <= 3'd1;
      TARGET <= 16'h0000;
    end else if (KEY_UP ^ KEY_DOWN) begin
      case (dest)
        16'd1: if (allowed(acc_target, CODE_OK))
          TARGET <= KEY_UP ? TARGET + 16'h0001 : TARGET - 16'h0001;
        16'd2: if (allowed(acc_prog, CODE_OK)) begin
          if (KEY_UP && 16'(PROGRAM) < prog_max)
            PROGRAM <= PROGRAM + 3'd1;
          else if (KEY_DOWN && 16'(PROGRAM) > prog_min)
            PROGRAM <= PROGRAM - 3'd1;
        end
        default: ;
      endcase
    end else if (WR_EN && ok_value && WR.page == `PAGE_PROGRAM && WR.item == 8'h01)
      PROGRAM <= WR.value[2:0];
  end
  assign BTN_UP = KEY_UP && dest == 16'd3 && allowed(acc_freq, CODE_OK);
  assign BTN_DOWN = KEY_DOWN && dest == 16'd3 && allowed(acc_freq, CODE_OK);
  assign MENU_ENABLE = lockout[4:0];
  assign ANALOG_ROUTE = route[2:0];

  always_comb begin
    case (RD_ITEM)
      `ITEM_DEVICE_TYPE: next_value = DEVICE_TYPE;
      `ITEM_SW_REV: next_value = SW_REV;
      `ITEM_COMMS_REV: next_value = COMMS_REV;
      `ITEM_STATUS: next_value = {8'h00, status};
      `ITEM_PICKUP_RPM: next_value = pick_rpm;
      `ITEM_PICKUP_ENG: next_value = DISPLAY_RPM;
      `ITEM_LEADER_RPM: next_value = lead_rpm;
      default: next_value = 16'h0000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      RD_ANS <= '0;
    else begin
      RD_ANS.ok <= RD_EN && RD_PAGE == `PAGE_MONITOR && RD_ITEM >= 8'h01 && RD_ITEM <= 8'h07;
      RD_ANS.value <= next_value;
    end
  end
endmodule // drive_supervision

/* core/drive_supervision_cfg.svh */
// constants for the drive supervision block: item numbers, limits, timing counts
// assumes a 125 MHz system clock; the cycle counts derive from CLK_HZ, TENTH_SEC_NS is a fixed figure
`ifndef DRIVE_SUPERVISION_CFG_SVH
`define DRIVE_SUPERVISION_CFG_SVH

`define CLK_HZ 125000000
`define TENTH_SEC_NS 100000000
`define TENTH_SEC_CYCLES (`CLK_HZ / 10)
`define MS10_CYCLES (`CLK_HZ / 100)
`define MINUTE_CYCLES (`CLK_HZ * 64'd60)

// page 0 monitor items
`define ITEM_DEVICE_TYPE 8'h01
`define ITEM_SW_REV 8'h02
`define ITEM_COMMS_REV 8'h03
`define ITEM_STATUS 8'h04
`define ITEM_PICKUP_RPM 8'h05
`define ITEM_PICKUP_ENG 8'h06
`define ITEM_LEADER_RPM 8'h07

// monitor page and settings pages
`define PAGE_MONITOR 8'h00
`define PAGE_CONTROL 8'h07
`define PAGE_PROGRAM 8'h08
`define PAGE_ACCESS 8'h09
`define PAGE_NETWORK 8'h0a
`define PAGE_ANALOG 8'h0b
`define PAGE_USER_OUT 8'h0c

// limits, in tenths of seconds where timed, turnaround in 10 ms units
`define INIT_STALL_MIN 16'd20
`define INIT_STALL_MAX 16'd250
`define INIT_STALL_RST 16'd250
`define RUN_STALL_MAX 16'd200
`define LEADER_STALL_RST 16'd65
`define PPR_MAX 16'd2500
`define FREQ_MAX 16'd9999
`define UPDATE_MIN 16'd2
`define UPDATE_MAX 16'd80
`define UPDATE_RST 16'd10
`define PROG_MIN 16'd1
`define PROG_MAX 16'd6
`define ACCESS_MAX 16'd2
`define DEST_MIN 16'd1
`define DEST_MAX 16'd3
`define CODE_MAX 16'd9999
`define LOCKOUT_ALL 16'd31
`define BAUD_MIN 16'd1
`define BAUD_MAX 16'd5
`define TURN_MIN 16'd1
`define TURN_MAX 16'd50
`define ROUTE_MAX 16'd6

// status flag positions
`define ST_MAIN_STALL 0
`define ST_LEADER_STALL 1
`define ST_RAMP 2
`define ST_INHIBIT 3
`define ST_BELOW 4
`define ST_ABOVE 5
`define ST_COND_MAX 6

`endif

/* core/drive_supervision_pkg.sv */
// types shared by the drive supervision block
// assumes drive_supervision_cfg.svh holds the numbers
package drive_supervision_pkg;
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] item;
    logic [15:0] value;
  } item_write_t;
  typedef struct packed {
    logic [15:0] value;
    logic ok;
  } item_answer_t;
  typedef enum logic [1:0] {ACCESS_LOCKED, ACCESS_FREE, ACCESS_CODE} access_t;
endpackage

/* core/pulse_rate.sv */
// period meter: converts one pulse input into rpm once per pulse
// assumes pulse is synchronised; ppr is 1..2500
module pulse_rate (
  input wire logic clk,
  input wire logic rst,
  input wire logic pulse,
  input wire logic [15:0] ppr,
  output logic [15:0] rpm
);
`include "drive_supervision_cfg.svh"
  logic [31:0] period;
  logic [47:0] prod;
  logic [47:0] quot;

  // instantaneous: every pulse recomputes, no averaging
  assign prod = 48'(period) * 48'(ppr);
  assign quot = (prod == 48'h0) ? 48'h0 : 48'(64'(`MINUTE_CYCLES) / 64'(prod));

  always_ff @(posedge clk) begin
    if (rst) begin
      period <= 32'h00000000;
      rpm <= 16'h0000;
    end else if (pulse) begin
      period <= 32'h00000001;
      rpm <= (quot > 48'h00000000ffff) ? 16'hffff : quot[15:0];
    end else if (period != 32'hffffffff) begin
      period <= period + 32'h00000001;
    end
  end
endmodule // pulse_rate

/* core/stall_timer.sv */
// stall watchdog for one pulse input, timeout counted in tenths of seconds
// assumes pulse is a synchronised single-cycle strobe on CLOCK
module stall_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic arm,
  input wire logic pulse,
  input wire logic [15:0] timeout,
  output logic stalled
);
`include "drive_supervision_cfg.svh"
  logic [23:0] tick;
  logic [15:0] tenths;

  always_ff @(posedge clk) begin
    if (rst || !arm || pulse || timeout == 16'h0000) begin
      tick <= 24'h000000;
      tenths <= 16'h0000;
    end else if (tick == 24'(`TENTH_SEC_CYCLES - 1)) begin
      tick <= 24'h000000;
      if (tenths != 16'hffff)
        tenths <= tenths + 16'h0001;
    end else begin
      tick <= tick + 24'h000001;
    end
  end

  // a zero timeout disables the watchdog
  always_ff @(posedge clk) begin
    if (rst || !arm || pulse || timeout == 16'h0000)
      stalled <= 1'b0;
    else if (tenths >= timeout)
      stalled <= 1'b1;
  end
endmodule // stall_timer

/* dv/drive_supervision_checker.sv */
// port-level checks for drive_supervision
// assumes it is bound to the top module and sees only its ports
module drive_supervision_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic RUN,
  input wire logic DRIVE_RAW,
  input wire logic WR_EN,
  input wire logic MSG_VALID,
  input wire logic [15:0] MSG_ADDR,
  input wire logic MSG_ACCEPT,
  input wire logic REPLY_GO,
  input wire logic [15:0] BAUD_RATE,
  input wire logic BTN_UP,
  input wire logic BTN_DOWN,
  input wire logic KEY_UP,
  input wire logic KEY_DOWN,
  input wire logic [2:0] PROGRAM,
  input wire logic [4:0] MENU_ENABLE,
  input wire logic [2:0] ANALOG_ROUTE,
  input wire logic DISPLAY_STROBE,
  input wire logic DRIVE_OUT,
  input wire logic MAIN_SHUTDOWN,
  input wire logic USER_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_accept_addr: assert property (MSG_ACCEPT |-> MSG_VALID && MSG_ADDR != 16'h0000)
    else $error("message accepted without a nonzero address");
  chk_baud_legal: assert property (BAUD_RATE inside
    {16'h012c, 16'h04b0, 16'h0960, 16'h12c0, 16'h2580}) else $error("baud rate off the list");
  chk_route_code: assert property (ANALOG_ROUTE <= 3'h6)
    else $error("routing code above six");
  chk_route_hold: assert property ($changed(ANALOG_ROUTE) |-> $past(WR_EN) || $past(RST))
    else $error("routing changed without a write");
  chk_menu_hold: assert property ($changed(MENU_ENABLE) |-> $past(WR_EN) || $past(RST))
    else $error("menu enables changed without a write");
  chk_program_span: assert property (PROGRAM >= 3'h1 && PROGRAM <= 3'h6)
    else $error("program number out of range");
  chk_button_key: assert property ((BTN_UP -> KEY_UP) && (BTN_DOWN -> KEY_DOWN))
    else $error("step without a key press");
  chk_stall_holdoff: assert property ($rose(RUN) |=> !MAIN_SHUTDOWN [*8])
    else $error("stall right after start");
  chk_shutdown_run: assert property ($rose(MAIN_SHUTDOWN) |-> $past(RUN))
    else $error("shutdown while not running");
  chk_reply_delay: assert property (MSG_ACCEPT |=> !REPLY_GO [*8])
    else $error("reply without turnaround delay");
  chk_display_gap: assert property (DISPLAY_STROBE |=> !DISPLAY_STROBE [*8])
    else $error("display refreshed too fast");
  // a polarity write two cycles back may flip the output on its own
  chk_drive_follow: assert property ($changed(DRIVE_OUT) && !$past(WR_EN, 2) && !$past(RST)
    && !$past(RST, 2) |-> $past(DRIVE_RAW) != $past(DRIVE_RAW, 2))
    else $error("drive output moved without its input");

  cov_accept: cover property (MSG_ACCEPT);
  cov_button: cover property (BTN_UP);
  cov_user: cover property ($rose(USER_OUT));
endmodule // drive_supervision_checker

bind drive_supervision drive_supervision_checker drive_supervision_checker_inst (.*);

/* dv/drive_supervision_tb.sv */
// testbench for drive_supervision: settings, codes, user output, speed monitors
// assumes the checker binds itself and pulse_source plays the sensors
module drive_supervision_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drive_supervision_pkg::*;
  localparam logic [15:0] DEV_ID = 16'h0123; // arbitrary value
  logic CLOCK = 1'b0, RST = 1'b1, RUN, RAMP_ACTIVE, INHIBIT, BELOW_LIMIT, ABOVE_LIMIT, COND_MAX;
  logic DRIVE_RAW, WR_EN, RD_EN, MSG_VALID, KEY_UP, KEY_DOWN, CODE_OK, pulses_on, ok;
  logic MSG_ACCEPT, REPLY_GO, BTN_UP, BTN_DOWN, DISPLAY_STROBE, FREQ_OUT, DRIVE_OUT;
  logic MAIN_SHUTDOWN, LEADER_STOPPED, USER_OUT, PICKUP_PIN, LEADER_PIN;
  item_write_t WR;
  item_answer_t WR_ANS, RD_ANS;
  logic [7:0] RD_PAGE, RD_ITEM;
  logic [15:0] MSG_ADDR, BAUD_RATE, TARGET, DISPLAY_RPM, v;
  logic [2:0] PROGRAM, ANALOG_ROUTE;
  logic [4:0] MENU_ENABLE, st;
  logic [6:0] m, inv;
  int num_errors = 0, n_checks = 0, r, d;
  int tab[15][5] = '{'{7, 5, 20, 250, 250}, '{7, 6, 0, 200, 0}, '{7, 7, 1, 2500, 1},
    '{7, 8, 0, 9999, 0}, '{7, 9, 0, 200, 65}, '{7, 10, 1, 2500, 1}, '{7, 11, 0, 1, 0},
    '{7, 12, 2, 80, 10}, '{9, 1, 0, 2, 1}, '{9, 2, 0, 2, 1}, '{9, 3, 0, 2, 1},
    '{9, 4, 1, 3, 1}, '{9, 6, 0, 31, 31}, '{10, 2, 1, 5, 5}, '{10, 3, 1, 50, 1}};
  int keys[6][5] = '{'{3, 1, 0, 0, 1}, '{3, 0, 0, 0, 0}, '{3, 2, 5, 0, 0}, '{3, 2, 5, 1, 1},
    '{3, 2, 0, 0, 1}, '{1, 1, 0, 0, 0}};

  always #4 CLOCK = ~CLOCK;
  drive_supervision #(.DEVICE_TYPE(DEV_ID)) drive_supervision_inst (.*);
  pulse_source pulse_source_inst (.en(pulses_on), .pick(PICKUP_PIN), .lead(LEADER_PIN));

  function automatic logic user_exp(logic pol, logic [6:0] mk, iv, fl);
    return pol ^ (|((fl ^ iv) & mk));
  endfunction
  function automatic logic [15:0] baud_exp(int c);
    case (c)
      1: return 16'h012c;
      2: return 16'h04b0;
      3: return 16'h0960;
      4: return 16'h12c0;
      default: return 16'h2580;
    endcase
  endfunction
  function automatic longint rpm_exp(longint per, ppr);
    return 64'h1bf08eb00 / (per * ppr);
  endfunction

  task automatic check(input logic good, input string msg);
    n_checks++;
    if (good !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input int p, i, val, input logic exp);
    @(posedge CLOCK);
    WR_EN <= 1'b1;
    WR <= '{p[7:0], i[7:0], val[15:0]};
    @(posedge CLOCK);
    WR_EN <= 1'b0;
    #1 check(WR_ANS.ok === exp, "write answer");
  endtask
  task automatic rd(input int p, i);
    @(posedge CLOCK);
    RD_EN <= 1'b1;
    RD_PAGE <= p[7:0];
    RD_ITEM <= i[7:0];
    @(posedge CLOCK);
    RD_EN <= 1'b0;
    #1 v = RD_ANS.value;
    ok = RD_ANS.ok;
  endtask
  task automatic rdchk(input int p, i, exp);
    rd(p, i);
    check(p == 0 ? ok === 1'b1 && v === exp[15:0] : ok === 1'b0, "read value");
  endtask
  task automatic msg(input logic [15:0] a, input logic exp);
    @(posedge CLOCK);
    MSG_VALID <= 1'b1;
    MSG_ADDR <= a;
    #1 check(MSG_ACCEPT === exp, "message accept");
    @(posedge CLOCK);
    MSG_VALID <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (70000) @(posedge CLOCK);
    num_errors++;
    end_of_test();
  end

  initial begin
    {DRIVE_RAW, WR_EN, RD_EN, MSG_VALID, KEY_UP, KEY_DOWN, CODE_OK, pulses_on, RUN} = '0;
    {RAMP_ACTIVE, INHIBIT, BELOW_LIMIT, ABOVE_LIMIT, COND_MAX} = '0;
    {WR, RD_PAGE, RD_ITEM, MSG_ADDR} = '0;
    void'($urandom(47));
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    // upper edge accepted, refusals past max and below a nonzero min; settings pages refuse reads
    foreach (tab[k]) begin
      rdchk(tab[k][0], tab[k][1], tab[k][4]);
      wr(tab[k][0], tab[k][1], tab[k][3] + 1, 1'b0);
      wr(tab[k][0], tab[k][1], tab[k][3], 1'b1);
      if (tab[k][2] > 0) wr(tab[k][0], tab[k][1], tab[k][2] - 1, 1'b0);
      rdchk(tab[k][0], tab[k][1], tab[k][3]);
      wr(tab[k][0], tab[k][1], tab[k][2] + $urandom_range(tab[k][3] - tab[k][2]), 1'b1);
      wr(tab[k][0], tab[k][1], tab[k][4], 1'b1);
    end
    $display("test settings done");
    wr(8, 2, 4, 1'b1);
    wr(8, 3, 3, 1'b0);
    wr(8, 1, 3, 1'b0);
    wr(8, 1, 5, 1'b1);
    check(PROGRAM === 3'h5, "program select");
    wr(8, 2, 1, 1'b1);
    $display("test program done");
    msg(16'h0007, 1'b0);
    wr(10, 1, 7, 1'b1);
    msg(16'h0007, 1'b1);
    msg(16'h0008, 1'b0);
    wr(10, 1, 0, 1'b1);
    msg(16'h0007, 1'b0);
    for (int c = 1; c <= 5; c++) begin
      wr(10, 2, c, 1'b1);
      check(BAUD_RATE === baud_exp(c), "baud rate");
    end
    $display("test network done");
    for (int c = 0; c <= 7; c++) begin
      wr(11, 1, c, c < 7);
      check(ANALOG_ROUTE === c[2:0] - (c == 7), "routing");
    end
    repeat (4) begin
      r = $urandom_range(31);
      wr(9, 6, r, 1'b1);
      check(MENU_ENABLE === r[4:0], "lockout");
    end
    repeat (4) begin
      d = $urandom_range(1);
      r = $urandom_range(1);
      wr(7, 11, r, 1'b1);
      @(posedge CLOCK) DRIVE_RAW <= d[0];
      repeat (2) @(posedge CLOCK);
      #1 check(DRIVE_OUT === (d[0] ^ r[0]), "drive polarity");
    end
    $display("test codes done");
    foreach (keys[k]) begin
      wr(9, 4, keys[k][0], 1'b1);
      wr(9, 3, keys[k][1], 1'b1);
      wr(9, 5, keys[k][2], 1'b1);
      @(posedge CLOCK);
      CODE_OK <= keys[k][3][0];
      KEY_UP <= 1'b1;
      #1 check(BTN_UP === keys[k][4][0], "button step");
      @(posedge CLOCK) KEY_UP <= 1'b0;
    end
    #1 check(TARGET === 16'h0001, "target step");
    $display("test buttons done");
    for (int k = 0; k < 6; k++) begin
      st = $urandom_range(31);
      m = (k == 0) ? 7'h00 : 7'($urandom_range(127));
      inv = (k == 1) ? 7'h00 : 7'($urandom_range(127));
      r = $urandom_range(1);
      @(posedge CLOCK);
      {COND_MAX, ABOVE_LIMIT, BELOW_LIMIT, INHIBIT, RAMP_ACTIVE} <= st;
      wr(12, 2, r, 1'b1);
      wr(12, 3, m, 1'b1);
      wr(12, 4, inv, 1'b1);
      repeat (2) @(posedge CLOCK);
      #1 check(USER_OUT === user_exp(r[0], m, inv, {st, 2'b00}), "user out");
      rdchk(0, 4, {st, 2'b00});
    end
    $display("test user output done");
    rdchk(0, 1, DEV_ID);
    rd(0, 8);
    check(ok === 1'b0, "unmapped item");
    wr(0, 4, 1, 1'b0);
    wr(7, 7, 2500, 1'b1);
    wr(7, 10, 1000, 1'b1);
    @(posedge CLOCK);
    pulses_on <= 1'b1;
    RUN <= 1'b1;
    repeat (40000) @(posedge CLOCK);
    check(MAIN_SHUTDOWN === 1'b0, "stall during start");
    check(FREQ_OUT === 1'b0, "frequency off");
    rd(0, 5);
    check(ok === 1'b1 && v - rpm_exp(6250, 2500) + 1 <= 2, "pickup rpm");
    rd(0, 7);
    check(ok === 1'b1 && v - rpm_exp(12500, 1000) + 1 <= 2, "leader rpm");
    RUN <= 1'b0;
    $display("test monitors done");
    end_of_test();
  end
endmodule // drive_supervision_tb

/* dv/pulse_source.sv */
// stand-in for the main pick-up and the leader: free-running pulse trains
// assumes the block samples both pins asynchronously
module pulse_source #(
  parameter int PICK_NS = 50000,
  parameter int LEAD_NS = 100000
) (
  input wire logic en,
  output logic pick,
  output logic lead
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pick = 1'b0;
    lead = 1'b0;
  end
  // 50 us is the fastest train the pick-up input has to take
  always begin
    wait (en);
    #(PICK_NS - 1003) pick = 1'b1;
    #1003 pick = 1'b0;
  end
  always begin
    wait (en);
    #(LEAD_NS - 1003) lead = 1'b1;
    #1003 lead = 1'b0;
  end
endmodule // pulse_source
